// ==== design/audio_in_pkg.sv ====
// Constants shared by the serial audio input selector
package audio_in_pkg;
  // Source select field position in control register two
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  localparam logic [1:0] SEL_C = 2'h2;
  // Format field position in control register zero
  localparam int FMT_HI = 3;
  localparam int FMT_LO = 0;
  localparam logic [3:0] FMT_RESET = 4'h0;
  // Auxiliary enable bit in control register one, forward enable in register two
  localparam int AUX_EN_BIT = 11;
  localparam int FWD_EN_BIT = 8;
  // Framing codes, low two bits of the format field
  localparam logic [1:0] MODE_I2S = 2'h0;
  localparam logic [1:0] MODE_LEFT = 2'h1;
  localparam logic [1:0] MODE_RIGHT = 2'h2;
  localparam logic [1:0] MODE_DSP = 2'h3;
  // Word length codes, high two bits of the format field
  localparam logic [1:0] LEN_16 = 2'h0;
  localparam logic [1:0] LEN_20 = 2'h1;
  localparam logic [1:0] LEN_24 = 2'h2;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_20 = 6'h14;
  localparam logic [5:0] BITS_24 = 6'h18;
  // Sample width presented to the core
  localparam int SAMPLE_W = 24;
  // Bit position counter saturation
  localparam logic [5:0] POS_MAX = 6'h3f;
  localparam logic [5:0] POS_ZERO = 6'h00;
  localparam logic [5:0] POS_ONE = 6'h01;
  // Synchroniser depth for every pin input
  localparam int SYNC_STAGES = 2;
endpackage

// ==== design/pin_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] pin, // Asynchronous pin levels
  output logic [WIDTH-1:0] level // Synchronised levels
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_level;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage
  always_comb begin
    next_meta = rst_n ? pin : '0;
    next_level = rst_n ? meta : '0;
  end

  // Both stages register on every rising clock edge
  always_ff @(posedge clk) begin
    meta <= next_meta;
    level <= next_level;
  end
endmodule

// ==== design/serial_audio_input_select.sv ====
// Serial audio input port: three-way source select, four framings, aux input
//
// Operation
// - Exactly one of the three serial data inputs feeds the receiver, chosen by the select field.
// - After reset the select field is 00, choosing data input a.
// - The four-bit format field decides how incoming words are decoded.
// - The select field also picks the active frame clock, input a after reset.
// - The select field also picks the active shift clock, input a after reset.
// - Frame and shift clocks are interpreted according to the programmed framing.
// - Left-justified, I2S, right-justified and DSP framings are all supported.
// - Every framing accepts 16, 20 or 24 bit words.
// - Words arrive MSB first in twos complement and are sign extended as such.
// - A four-channel mode uses the selected main input and the aux input together.
// - Up to three sources may be chosen for serial data and for the master clock.
// - The shared pin becomes an aux two-channel data input when the aux enable is set.
// - The aux input uses the same selected shift and frame clocks as the main inputs.
// - The selected group is forwarded on the mux outputs only while forwarding is enabled.
`timescale 1ns/100ps
module serial_audio_input_select (
  input wire logic MCLK, // System clock, 25 MHz
  input wire logic NRST, // Synchronous reset, active low
  input wire logic SERIAL_IN_A, // Serial data group a
  input wire logic SERIAL_IN_B, // Serial data group b
  input wire logic SERIAL_IN_C, // Serial data group c
  input wire logic FRAME_CLOCK_A, // Frame clock group a
  input wire logic FRAME_CLOCK_B, // Frame clock group b
  input wire logic FRAME_CLOCK_C, // Frame clock group c
  input wire logic SHIFT_CLOCK_A, // Shift clock group a
  input wire logic SHIFT_CLOCK_B, // Shift clock group b
  input wire logic SHIFT_CLOCK_C, // Shift clock group c
  input wire logic DEEMPHASIS_OR_AUX_INPUT, // De-emphasis request or aux data
  input wire logic MASTER_CLOCK_IN_A, // Master clock source a
  input wire logic MASTER_CLOCK_IN_B, // Master clock source b
  input wire logic MASTER_CLOCK_IN_C, // Master clock source c
  input wire logic [1:0] SOURCE_SELECT, // Serial group select field
  input wire logic [1:0] MASTER_SELECT, // Master clock source select
  input wire logic [3:0] FORMAT, // Framing and word length field
  input wire logic AUX_ENABLE, // Shared pin acts as aux data
  input wire logic FORWARD_ENABLE, // Drive the mux output pins
  output logic FORWARDED_SERIAL_OUT, // Selected data, forwarded
  output logic FORWARDED_FRAME_CLOCK, // Selected frame clock, forwarded
  output logic FORWARDED_SHIFT_CLOCK, // Selected shift clock, forwarded
  output logic MASTER_CLOCK_SAMPLED, // Selected master clock as sampled
  output logic DEEMPHASIS_REQUEST, // Pin level in de-emphasis use
  output logic [1:0] ACTIVE_SOURCE, // Source currently received
  output logic [23:0] LEFT_SAMPLE, // Main left word, sign extended
  output logic [23:0] RIGHT_SAMPLE, // Main right word, sign extended
  output logic [23:0] AUX_LEFT_SAMPLE, // Aux left word, sign extended
  output logic [23:0] AUX_RIGHT_SAMPLE, // Aux right word, sign extended
  output logic SAMPLE_VALID // One-cycle pulse per completed frame
);

  ////////////////////////////////////////////////////////////////////////////
  // Every pin passes two flip-flops before any logic reads it
  logic [12:0] synced;
  logic d_a, d_b, d_c, f_a, f_b, f_c, s_a, s_b, s_c, aux_pin, mc_a, mc_b, mc_c;

  pin_sync #(.WIDTH(13)) u_sync (
    .clk(MCLK),
    .rst_n(NRST),
    .pin({MASTER_CLOCK_IN_C, MASTER_CLOCK_IN_B, MASTER_CLOCK_IN_A, DEEMPHASIS_OR_AUX_INPUT,
          SHIFT_CLOCK_C, SHIFT_CLOCK_B, SHIFT_CLOCK_A, FRAME_CLOCK_C, FRAME_CLOCK_B,
          FRAME_CLOCK_A, SERIAL_IN_C, SERIAL_IN_B, SERIAL_IN_A}),
    .level(synced)
  );

  assign {mc_c, mc_b, mc_a, aux_pin, s_c, s_b, s_a, f_c, f_b, f_a, d_c, d_b, d_a} = synced;

  ////////////////////////////////////////////////////////////////////////////
  // Group and master clock selection
  logic sel_d, sel_f, sel_s, sel_mc;

  // Unused code 11 falls back to group a so the port never floats
  always_comb begin
    case (ACTIVE_SOURCE)
      audio_in_pkg::SEL_B: begin
        sel_d = d_b;
        sel_f = f_b;
        sel_s = s_b;
      end
      audio_in_pkg::SEL_C: begin
        sel_d = d_c;
        sel_f = f_c;
        sel_s = s_c;
      end
      default: begin
        sel_d = d_a;
        sel_f = f_a;
        sel_s = s_a;
      end
    endcase
    case (MASTER_SELECT)
      audio_in_pkg::SEL_B: sel_mc = mc_b;
      audio_in_pkg::SEL_C: sel_mc = mc_c;
      default: sel_mc = mc_a;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Format decode
  logic [1:0] mode;
  logic [5:0] wlen;
  logic [5:0] dly;

  always_comb begin
    mode = FORMAT[1:0];
    case (FORMAT[3:2])
      audio_in_pkg::LEN_16: wlen = audio_in_pkg::BITS_16;
      audio_in_pkg::LEN_20: wlen = audio_in_pkg::BITS_20;
      default: wlen = audio_in_pkg::BITS_24;
    endcase
    // I2S and DSP framings put the MSB one shift clock after the frame edge
    dly = (mode == audio_in_pkg::MODE_I2S || mode == audio_in_pkg::MODE_DSP) ?
          audio_in_pkg::POS_ONE : audio_in_pkg::POS_ZERO;
  end

  // Sign extend the low n bits of a shift register to a full sample
  function automatic logic [23:0] sext(input logic [23:0] v, input logic [5:0] n);
    logic [23:0] r;
    r = v;
    if (n == audio_in_pkg::BITS_16) begin
      r = {{8{v[15]}}, v[15:0]};
    end else if (n == audio_in_pkg::BITS_20) begin
      r = {{4{v[19]}}, v[19:0]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Receiver state
  logic s_prev, f_prev;
  logic [5:0] pos;
  logic [23:0] sh, ash;
  logic next_s_prev, next_f_prev, next_valid;
  logic [5:0] next_pos;
  logic [23:0] next_sh, next_ash, next_left, next_right, next_aux_l, next_aux_r;
  logic [1:0] next_source;
  logic rise, edge_f, take, done_l, done_r;
  logic [5:0] last_l;
  logic [5:0] last_r;

  // Bits are sampled on the rising shift clock; the frame clock is read there too
  always_comb begin
    next_s_prev = sel_s;
    next_f_prev = f_prev;
    next_pos = pos;
    next_sh = sh;
    next_ash = ash;
    next_left = LEFT_SAMPLE;
    next_right = RIGHT_SAMPLE;
    next_aux_l = AUX_LEFT_SAMPLE;
    next_aux_r = AUX_RIGHT_SAMPLE;
    next_valid = 1'b0;
    next_source = ACTIVE_SOURCE;
    rise = sel_s & ~s_prev;
    edge_f = sel_f != f_prev;
    take = 1'b0;
    done_l = 1'b0;
    done_r = 1'b0;
    last_l = dly + wlen - audio_in_pkg::POS_ONE;
    last_r = last_l + wlen;
    if (rise) begin
      next_f_prev = sel_f;
      if (mode == audio_in_pkg::MODE_DSP) begin
        // Frame pulse rising starts the left slot; right follows directly
        next_pos = (edge_f && sel_f) ? audio_in_pkg::POS_ZERO :
                   (pos == audio_in_pkg::POS_MAX) ? pos : pos + audio_in_pkg::POS_ONE;
        take = next_pos >= dly && next_pos <= last_r;
        done_l = take && next_pos == last_l;
        done_r = take && next_pos == last_r;
      end else if (mode == audio_in_pkg::MODE_RIGHT) begin
        // Word ends at the frame edge, so shift always and capture there
        take = 1'b1;
        done_l = edge_f && f_prev;
        done_r = edge_f && !f_prev;
      end else begin
        next_pos = edge_f ? audio_in_pkg::POS_ZERO :
                   (pos == audio_in_pkg::POS_MAX) ? pos : pos + audio_in_pkg::POS_ONE;
        take = next_pos >= dly && next_pos <= last_l;
        // I2S left has the frame clock low, left-justified has it high
        done_l = take && next_pos == last_l && (sel_f ^ (mode == audio_in_pkg::MODE_I2S));
        done_r = take && next_pos == last_l && !(sel_f ^ (mode == audio_in_pkg::MODE_I2S));
      end
      if (mode == audio_in_pkg::MODE_RIGHT) begin
        // Capture before shifting: the edge bit already belongs to the next word
        if (done_l) begin
          next_left = sext(sh, wlen);
          next_aux_l = AUX_ENABLE ? sext(ash, wlen) : '0;
        end
        if (done_r) begin
          next_right = sext(sh, wlen);
          next_aux_r = AUX_ENABLE ? sext(ash, wlen) : '0;
        end
      end
      if (take) begin
        next_sh = {sh[22:0], sel_d};
        next_ash = {ash[22:0], aux_pin & AUX_ENABLE};
      end
      if (mode != audio_in_pkg::MODE_RIGHT) begin
        if (done_l) begin
          next_left = sext(next_sh, wlen);
          next_aux_l = AUX_ENABLE ? sext(next_ash, wlen) : '0;
        end
        if (done_r) begin
          next_right = sext(next_sh, wlen);
          next_aux_r = AUX_ENABLE ? sext(next_ash, wlen) : '0;
        end
      end
      if (done_r) begin
        next_valid = 1'b1;
        // Switching only after the right word keeps every pair from one source
        next_source = SOURCE_SELECT;
      end
    end
    if (!NRST) begin
      next_s_prev = 1'b0;
      next_f_prev = 1'b0;
      next_pos = audio_in_pkg::POS_MAX;
      next_sh = '0;
      next_ash = '0;
      next_left = '0;
      next_right = '0;
      next_aux_l = '0;
      next_aux_r = '0;
      next_valid = 1'b0;
      next_source = audio_in_pkg::SEL_RESET;
    end
  end

  always_ff @(posedge MCLK) begin
    s_prev <= next_s_prev;
    f_prev <= next_f_prev;
    pos <= next_pos;
    sh <= next_sh;
    ash <= next_ash;
    LEFT_SAMPLE <= next_left;
    RIGHT_SAMPLE <= next_right;
    AUX_LEFT_SAMPLE <= next_aux_l;
    AUX_RIGHT_SAMPLE <= next_aux_r;
    SAMPLE_VALID <= next_valid;
    ACTIVE_SOURCE <= next_source;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding, de-emphasis and master clock outputs
  logic next_fwd_d, next_fwd_f, next_fwd_s, next_mc, next_deemph;

  // Forwarded pins lag the inputs by the synchroniser plus one register
  always_comb begin
    next_fwd_d = NRST & FORWARD_ENABLE & sel_d;
    next_fwd_f = NRST & FORWARD_ENABLE & sel_f;
    next_fwd_s = NRST & FORWARD_ENABLE & sel_s;
    next_mc = NRST & sel_mc;
    next_deemph = NRST & ~AUX_ENABLE & aux_pin;
  end

  always_ff @(posedge MCLK) begin
    FORWARDED_SERIAL_OUT <= next_fwd_d;
    FORWARDED_FRAME_CLOCK <= next_fwd_f;
    FORWARDED_SHIFT_CLOCK <= next_fwd_s;
    MASTER_CLOCK_SAMPLED <= next_mc;
    DEEMPHASIS_REQUEST <= next_deemph;
  end
endmodule

// ==== tb/audio_in_properties.sv ====
// Port assertions for the serial audio input selector
`timescale 1ns/100ps
module audio_in_properties (
  input wire logic MCLK, // Clock
  input wire logic NRST, // Reset
  input wire logic SHIFT_CLOCK_A, // Pin
  input wire logic FRAME_CLOCK_A, // Pin
  input wire logic SERIAL_IN_A, // Pin
  input wire logic MASTER_CLOCK_IN_A, // Pin
  input wire logic MASTER_CLOCK_IN_B, // Pin
  input wire logic [1:0] SOURCE_SELECT, // Field
  input wire logic [1:0] MASTER_SELECT, // Field
  input wire logic AUX_ENABLE, // Bit
  input wire logic FORWARD_ENABLE, // Bit
  input wire logic FORWARDED_SERIAL_OUT, // Out
  input wire logic FORWARDED_SHIFT_CLOCK, // Out
  input wire logic FORWARDED_FRAME_CLOCK, // Out
  input wire logic MASTER_CLOCK_SAMPLED, // Out
  input wire logic DEEMPHASIS_REQUEST, // Out
  input wire logic [1:0] ACTIVE_SOURCE, // Out
  input wire logic [23:0] AUX_LEFT_SAMPLE, // Out
  input wire logic [23:0] AUX_RIGHT_SAMPLE, // Out
  input wire logic SAMPLE_VALID // Out
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  //////////////////////////////////////////////////////////////////////////////////////////
  // Steady windows long enough to flush the two synchroniser flops and the output flop
  sequence s_fwd_a; (FORWARD_ENABLE && ACTIVE_SOURCE == 2'h0) [*4]; endsequence
  sequence s_mclk_b; (MASTER_SELECT == 2'h1 && MASTER_CLOCK_IN_B) [*5]; endsequence
  // Source only moves at a completed frame, so no mixed-source pair reaches the core
  property p_reset_clear; $rose(NRST) |-> ACTIVE_SOURCE == 2'h0 && !SAMPLE_VALID; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");
  property p_valid_gap; SAMPLE_VALID |=> !SAMPLE_VALID [*8]; endproperty
  a_valid_gap: assert property (p_valid_gap) else $error("valid pulse too long");
  property p_src_take;
    SAMPLE_VALID |-> ACTIVE_SOURCE == $past(SOURCE_SELECT);
  endproperty
  a_src_take: assert property (p_src_take) else $error("wrong source taken");
  property p_src_hold; $changed(ACTIVE_SOURCE) |-> SAMPLE_VALID; endproperty
  a_src_hold: assert property (p_src_hold) else $error("source moved mid frame");
  property p_aux_off;
    SAMPLE_VALID && !$past(AUX_ENABLE) |-> AUX_LEFT_SAMPLE == 24'h0 && AUX_RIGHT_SAMPLE == 24'h0;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux data while disabled");
  property p_fwd_off;
    !FORWARD_ENABLE |=> !FORWARDED_SERIAL_OUT && !FORWARDED_SHIFT_CLOCK && !FORWARDED_FRAME_CLOCK;
  endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("forwarding while off");
  property p_fwd_copy; s_fwd_a |-> FORWARDED_SHIFT_CLOCK == $past(SHIFT_CLOCK_A, 3); endproperty
  a_fwd_copy: assert property (p_fwd_copy) else $error("forwarded clock wrong");
  property p_mclk_sel; s_mclk_b |-> MASTER_CLOCK_SAMPLED; endproperty
  a_mclk_sel: assert property (p_mclk_sel) else $error("master source wrong");
  // Frame clock and data copies share the shift clock's three-edge lag
  property p_fwd_frame;
    s_fwd_a |-> FORWARDED_FRAME_CLOCK == $past(FRAME_CLOCK_A, 3);
  endproperty
  a_fwd_frame: assert property (p_fwd_frame) else $error("fwd frame wrong");
  property p_fwd_data;
    s_fwd_a |-> FORWARDED_SERIAL_OUT == $past(SERIAL_IN_A, 3);
  endproperty
  a_fwd_data: assert property (p_fwd_data) else $error("fwd data wrong");
  // A toggling source a proves the sampled master clock is a live copy, not a constant
  sequence s_mclk_a; (MASTER_SELECT == 2'h0) [*4]; endsequence
  property p_mclk_copy;
    s_mclk_a |-> MASTER_CLOCK_SAMPLED == $past(MASTER_CLOCK_IN_A, 3);
  endproperty
  a_mclk_copy: assert property (p_mclk_copy) else $error("master copy wrong");
  // Aux data on the shared pin must never read as a de-emphasis request
  property p_deemph_off; AUX_ENABLE |=> !DEEMPHASIS_REQUEST; endproperty
  a_deemph_off: assert property (p_deemph_off) else $error("deemph while aux");
endmodule

// ==== tb/audio_src_model.sv ====
// Behavioural external audio source sending one serial frame on request
`timescale 1ns/100ps
module audio_src_model (
  output logic sdata, // Main serial data
  output logic adata, // Aux serial data on the same clocks
  output logic fclk, // Frame clock
  output logic bclk // Shift clock, 320 ns, stands low between frames
);
  localparam int SLOT = 32; // Shift clocks per channel slot
  //////////////////////////////////////////////////////////////////////////////////////////
  // Idle levels; unused bits invert so a stale value is never mistaken for data
  initial begin
    {sdata, adata, fclk, bclk} = 4'h6;
  end
  // Lead bit sets the old frame level, trail bit gives right-justified words their end edge
  task automatic send(input logic [1:0] mode, input int n, input logic [23:0] l, r, al, ar);
    int j, i;
    logic c, ll, dsp;
    dsp = (mode == audio_in_pkg::MODE_DSP);
    ll = (mode != audio_in_pkg::MODE_I2S);
    for (int k = 0; k < 2 * SLOT + 2; k++) begin
      j = k - 1;
      c = dsp ? (j > n) : (j >= SLOT);
      i = dsp ? j - 1 - (c ? n : 0) : j % SLOT - (mode == audio_in_pkg::MODE_LEFT ? 0 :
          mode == audio_in_pkg::MODE_RIGHT ? SLOT - n : 1);
      bclk = 1'b0;
      fclk = dsp ? (k == 1) : (k == 0) ? !ll : (k <= SLOT || k > 2 * SLOT) ? ll : !ll;
      if (k > 0 && k <= 2 * SLOT && i >= 0 && i < n) begin
        sdata = c ? r[n - 1 - i] : l[n - 1 - i];
        adata = c ? ar[n - 1 - i] : al[n - 1 - i];
      end else begin
        {sdata, adata} = ~{sdata, adata};
      end
      #160 bclk = 1'b1;
      #160;
    end
    bclk = 1'b0;
    {sdata, adata} = ~{sdata, adata};
  endtask
endmodule

// ==== tb/test_serial_audio_input_select.sv ====
// Self-checking bench for the serial audio input selector
`timescale 1ns/100ps
module test_serial_audio_input_select;
  logic MCLK, NRST, SERIAL_IN_A, SERIAL_IN_B, SERIAL_IN_C, FRAME_CLOCK_A, FRAME_CLOCK_B;
  logic FRAME_CLOCK_C, SHIFT_CLOCK_A, SHIFT_CLOCK_B, SHIFT_CLOCK_C, DEEMPHASIS_OR_AUX_INPUT;
  logic MASTER_CLOCK_IN_A, MASTER_CLOCK_IN_B, MASTER_CLOCK_IN_C, AUX_ENABLE, FORWARD_ENABLE;
  logic FORWARDED_SERIAL_OUT, FORWARDED_FRAME_CLOCK, FORWARDED_SHIFT_CLOCK, deemph;
  logic MASTER_CLOCK_SAMPLED, DEEMPHASIS_REQUEST, SAMPLE_VALID, m_d, m_a, m_f, m_b;
  logic [1:0] SOURCE_SELECT, MASTER_SELECT, ACTIVE_SOURCE, route;
  logic [3:0] FORMAT;
  logic [23:0] LEFT_SAMPLE, RIGHT_SAMPLE, AUX_LEFT_SAMPLE, AUX_RIGHT_SAMPLE;
  int fail_count = 0;
  int cmp_count = 0;
  int vcnt = 0;
  serial_audio_input_select dut_u (.*);
  audio_src_model src_u (.sdata(m_d), .adata(m_a), .fclk(m_f), .bclk(m_b));
  // Unrouted groups carry inverted data, so a wrong selection shows in every word
  assign SERIAL_IN_A = (route == 2'h0) ? m_d : !m_d;
  assign SERIAL_IN_B = (route == 2'h1) ? m_d : !m_d;
  assign SERIAL_IN_C = (route == 2'h2) ? m_d : !m_d;
  assign {FRAME_CLOCK_A, FRAME_CLOCK_B, FRAME_CLOCK_C} = {3{m_f}};
  assign {SHIFT_CLOCK_A, SHIFT_CLOCK_B, SHIFT_CLOCK_C} = {3{m_b}};
  assign DEEMPHASIS_OR_AUX_INPUT = AUX_ENABLE ? m_a : deemph;
  assign {MASTER_CLOCK_IN_A, MASTER_CLOCK_IN_B, MASTER_CLOCK_IN_C} = {m_b, 2'h2};
  // Clock and frame completion count
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = !MCLK;
  end
  // Counted at the falling edge, where the registered pulse has settled
  always @(negedge MCLK) begin
    if (SAMPLE_VALID === 1'b1) vcnt++;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // Sign extension of an n-bit word
  function automatic logic [23:0] sx(input logic [23:0] w, input int n);
    return $signed(w << (24 - n)) >>> (24 - n);
  endfunction
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // One frame from the source; inv means the old, unrouted group is still received
  task automatic frame(input logic inv);
    int n, v0;
    n = 16 + 4 * FORMAT[3:2];
    v0 = vcnt;
    @(negedge MCLK);
    src_u.send(FORMAT[1:0], n, 24'hc8a3f5, 24'h35e24b, 24'h71b6c9, 24'h0f4e87);
    repeat (12) @(negedge MCLK);
    chk("valid", 24'h1, 24'(vcnt > v0));
    chk("left", sx(inv ? 24'h375c0a : 24'hc8a3f5, n), LEFT_SAMPLE);
    chk("right", sx(inv ? 24'hca1db4 : 24'h35e24b, n), RIGHT_SAMPLE);
    chk("aux l", AUX_ENABLE ? sx(24'h71b6c9, n) : 24'h0, AUX_LEFT_SAMPLE);
    chk("aux r", AUX_ENABLE ? sx(24'h0f4e87, n) : 24'h0, AUX_RIGHT_SAMPLE);
    chk("source", {22'h0, SOURCE_SELECT}, {22'h0, ACTIVE_SOURCE});
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {NRST, SOURCE_SELECT, MASTER_SELECT, route, FORMAT, FORWARD_ENABLE, deemph} = 13'h0;
    AUX_ENABLE = 1'b1;
    repeat (12) @(negedge MCLK);
    chk("reset source", 24'h0, {22'h0, ACTIVE_SOURCE});
    NRST = 1'b1;
    // Every framing at every word length; forwarding on for left-justified frames
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 3; w++) begin
        FORMAT = {w[1:0], m[1:0]};
        FORWARD_ENABLE = (m == 1);
        frame(1'b0);
      end
    end
    // Select changes, code 3 included; the frame in flight still comes from the old group
    FORWARD_ENABLE = 1'b0;
    FORMAT = 4'h1;
    for (int s = 1; s < 4; s++) begin
      SOURCE_SELECT = s[1:0];
      route = (s == 3) ? 2'h0 : s[1:0];
      frame(1'b1);
      frame(1'b0);
    end
    // Mid-run reset while code 3 is held must bring the receiver back to source 00
    NRST = 1'b0;
    repeat (3) @(negedge MCLK);
    chk("reset source", 24'h0, {22'h0, ACTIVE_SOURCE});
    NRST = 1'b1;
    // Aux off: zero aux words, shared pin read as a de-emphasis level
    AUX_ENABLE = 1'b0;
    frame(1'b0);
    deemph = 1'b1;
    MASTER_SELECT = 2'h1;
    repeat (8) @(negedge MCLK);
    chk("deemphasis", 24'h1, {23'h0, DEEMPHASIS_REQUEST});
    chk("master", 24'h1, {23'h0, MASTER_CLOCK_SAMPLED});
    test_done();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge MCLK);
    fail_count++;
    test_done();
  end
endmodule
bind serial_audio_input_select audio_in_properties chk_u (.*);
